//--- rtl/aip_module.sv
// analog input module: parameter bytes, diagnostic record, value format
`timescale 1ns/1ps
module aip_module (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_ce,
    aip_link_if.dev lnk,
    input wire logic i_smp_vld,
    input wire logic [1:0] i_smp_ch,
    input wire logic signed [15:0] i_smp_val,
    input wire logic i_supply_ok,
    output logic [aip_pkg::NCH-1:0][15:0] o_meas,
    output logic [aip_pkg::NCH-1:0] o_meas_vld,
    output logic [aip_pkg::NCH-1:0] o_rej_60,
    output logic [aip_pkg::NCH-1:0] o_rej_50,
    output logic [aip_pkg::NCH-1:0] o_ch_err_led,
    output logic o_mod_err_led
);
    import aip_pkg::*;

    typedef struct packed {
        logic [7:0] rej;
        logic [NCH-1:0][7:0] fn;
        logic [NCH-1:0][15:0] meas;
        logic [NCH-1:0] meas_vld;
        logic [NCH-1:0] over;
        logic [NCH-1:0] under;
        logic [NCH-1:0] r60;
        logic [NCH-1:0] r50;
        logic sup_m;
        logic sup_s;
        logic [7:0] presc;
        logic [31:0] us;
        logic [31:0] tstamp;
        logic [7:0] summ;
        logic [NCH-1:0] grp;
        logic [NCH-1:0][7:0] group_error_flags;
        logic [NCH-1:0] led;
        logic mled;
        logic ack;
        logic nack;
        logic [31:0] rdata;
    } aip_dev_st_t;

    aip_dev_st_t s_r;
    aip_dev_st_t s_nxt;

    logic phit;
    logic dhit;
    logic tshit;
    logic [2:0] pidx;
    logic [7:0] dsel;
    logic [NCH-1:0] prm;
    logic [NCH-1:0] off;
    logic signed [15:0] raw;

    // saturate a value into the range of the selected format
    function automatic logic [15:0] clamp(input logic signed [15:0] v,
                                          input logic signed [15:0] hi,
                                          input logic signed [15:0] lo);
        logic [15:0] r;
        r = v;
        if (v > hi) begin
            r = hi;
        end else if (v < lo) begin
            r = lo;
        end
        return r;
    endfunction

    // rescale the 27648-based input to the 16384-based format; rounded,
    // since plain truncation would leave full scale one count short
    function automatic logic signed [15:0] scale_s5(
            input logic signed [15:0] v);
        logic signed [32:0] p;
        p = v * $signed({1'b0, S5_MUL}) + 33'sh8000;
        return p[31:16];
    endfunction

    // one byte of the diagnostic record by its position
    function automatic logic [7:0] diag_byte(input aip_dev_st_t st,
                                             input logic [7:0] i);
        logic [7:0] b;
        b = 8'h00;
        case (i)
            8'h00: b = st.summ;
            8'h01: b = MOD_CLASS;
            8'h04: b = CH_KIND;
            8'h05: b = DIAG_BITS;
            8'h06: b = CH_COUNT;
            8'h07: b = {4'h0, st.grp};
            8'h08: b = st.group_error_flags[0];
            8'h09: b = st.group_error_flags[1];
            8'h0A: b = st.group_error_flags[2];
            8'h0B: b = st.group_error_flags[3];
            8'h10: b = st.tstamp[7:0];
            8'h11: b = st.tstamp[15:8];
            8'h12: b = st.tstamp[23:16];
            8'h13: b = st.tstamp[31:24];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.nack = 1'b0;
        s_nxt.rdata = 32'h0000_0000;
        s_nxt.meas_vld = '0;
        phit = 1'b0;
        dhit = 1'b0;
        tshit = 1'b0;
        pidx = 3'h0;
        dsel = lnk.sub;
        raw = i_smp_val;

        // supply pin comes from outside, two stages first
        s_nxt.sup_m = i_supply_ok;
        s_nxt.sup_s = s_r.sup_m;

        // free-running ticker, wraps at 2^32-1 on its own
        if (s_r.presc == 8'(CYC_PER_US - 1)) begin
            s_nxt.presc = 8'h00;
            s_nxt.us = s_r.us + 32'h0000_0001;
        end else begin
            s_nxt.presc = s_r.presc + 8'h01;
        end

        // address decode per access space; the answer is always one cycle
        // later so the coupler never has to poll
        if (lnk.req) begin
            s_nxt.ack = 1'b1;
            case (lnk.space)
                SP_REC: begin
                    if (lnk.wr && lnk.sub == 8'h00) begin
                        if (lnk.idx == REC_REJ) begin
                            phit = 1'b1;
                        end else if (lnk.idx >= REC_FN0 &&
                                     lnk.idx < REC_FN0 + 16'h0004) begin
                            phit = 1'b1;
                            pidx = 3'(lnk.idx - REC_FN0) + 3'h1;
                        end
                    end else if (!lnk.wr && lnk.idx == REC_DIAG) begin
                        dhit = lnk.sub < DIAG_LEN;
                    end else if (!lnk.wr && lnk.idx == REC_DIAG_HDR) begin
                        dhit = lnk.sub < DIAG_HDR_LEN;
                    end
                end
                SP_COE: begin
                    if (lnk.sub == 8'h00 && lnk.idx >= IX_PARAM &&
                        lnk.idx <= IX_PARAM + 16'h0004) begin
                        phit = 1'b1;
                        pidx = 3'(lnk.idx - IX_PARAM);
                    end else if (!lnk.wr && lnk.idx == IX_DIAG) begin
                        dhit = lnk.sub < DIAG_LEN;
                    end else if (!lnk.wr && lnk.idx == IX_DIAG_HDR) begin
                        dhit = lnk.sub < DIAG_HDR_LEN;
                    end
                end
                SP_ECAT: begin
                    if (lnk.idx == IX_PARAM + {8'h00, lnk.slot} &&
                        lnk.sub >= SX_REJ &&
                        lnk.sub <= SX_REJ + 8'h04) begin
                        phit = 1'b1;
                        pidx = 3'(lnk.sub - SX_REJ);
                    end else if (!lnk.wr && lnk.idx == IX_ECAT_DIAG) begin
                        if (lnk.sub == SX_TSTAMP) begin
                            tshit = 1'b1;
                        end else if (lnk.sub >= SX_DIAG0 &&
                                     lnk.sub <= SX_RSVD_LAST) begin
                            dhit = 1'b1;
                            dsel = lnk.sub - SX_DIAG0;
                        end
                    end
                end
                default: begin
                end
            endcase

            if (phit) begin
                if (pidx == 3'h0) begin
                    s_nxt.rdata = {24'h0, s_r.rej};
                    if (lnk.wr) begin
                        s_nxt.rej = lnk.wdata;
                    end
                end else begin
                    s_nxt.rdata = {24'h0, s_r.fn[2'(pidx - 3'h1)]};
                    if (lnk.wr) begin
                        s_nxt.fn[2'(pidx - 3'h1)] = lnk.wdata;
                    end
                end
            end else if (dhit) begin
                s_nxt.rdata = {24'h0, diag_byte(s_r, dsel)};
            end else if (tshit) begin
                s_nxt.rdata = s_r.tstamp;
            end else begin
                s_nxt.nack = 1'b1;
            end
        end

        // per-channel parameter check and rejection decode
        for (int c = 0; c < NCH; c++) begin
            off[c] = s_nxt.fn[c] == FN_OFF;
            prm[c] = s_nxt.rej[2*c+:2] == 2'h3 ||
                     !(s_nxt.fn[c] == FN_S7 || s_nxt.fn[c] == FN_S5 ||
                       off[c]);
            s_nxt.r60[c] = s_nxt.rej[2*c+:2] == REJ_60;
            s_nxt.r50[c] = s_nxt.rej[2*c+:2] == REJ_50;
        end

        // conversions of a disabled or misconfigured channel are dropped
        if (i_smp_vld && !off[i_smp_ch] && !prm[i_smp_ch]) begin
            s_nxt.meas_vld[i_smp_ch] = 1'b1;
            s_nxt.over[i_smp_ch] = raw > S7_OVER;
            s_nxt.under[i_smp_ch] = raw < S7_UNDER;
            if (s_nxt.fn[i_smp_ch] == FN_S5) begin
                s_nxt.meas[i_smp_ch] =
                    clamp(scale_s5(raw), S5_OVER, S5_UNDER);
            end else begin
                s_nxt.meas[i_smp_ch] = clamp(raw, S7_OVER, S7_UNDER);
            end
        end

        // flags track the present condition only
        for (int c = 0; c < NCH; c++) begin
            if (off[c] || prm[c]) begin
                s_nxt.over[c] = 1'b0;
                s_nxt.under[c] = 1'b0;
            end
            if (off[c]) begin
                s_nxt.meas[c] = 16'h0000;
            end
            s_nxt.group_error_flags[c] = 8'h00;
            s_nxt.group_error_flags[c][CHE_PRM] = prm[c];
            s_nxt.group_error_flags[c][CHE_UNDER] = s_nxt.under[c];
            s_nxt.group_error_flags[c][CHE_OVER] = s_nxt.over[c];
            s_nxt.grp[c] = |s_nxt.group_error_flags[c];
            s_nxt.led[c] = s_nxt.grp[c];
        end

        // summary byte; internal error is never raised here
        s_nxt.summ = 8'h00;
        s_nxt.summ[SUM_AUX] = !s_r.sup_s;
        s_nxt.summ[SUM_PRM] = |prm;
        s_nxt.summ[SUM_CH] = |s_nxt.grp;
        s_nxt.summ[SUM_EXT] = !s_r.sup_s || |(s_nxt.over | s_nxt.under);
        s_nxt.summ[SUM_FAIL] = s_nxt.summ[SUM_EXT] || |prm;
        s_nxt.mled = s_nxt.summ[SUM_FAIL];

        // stamp the ticker when a new error shows up; no interrupt is
        // raised, the coupler fetches the record when it wants
        if (|({s_nxt.summ, s_nxt.group_error_flags} & ~{s_r.summ, s_r.group_error_flags})) begin
            s_nxt.tstamp = s_r.us;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r <= '0;
            s_r.rej <= RST_REJ;
            s_r.fn <= {NCH{RST_FN}};
            s_r.sup_s <= 1'b1; // assume supply good until sampled
            s_r.sup_m <= 1'b1;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    assign lnk.ack = s_r.ack;
    assign lnk.nack = s_r.nack;
    assign lnk.rdata = s_r.rdata;
    assign o_meas = s_r.meas;
    assign o_meas_vld = s_r.meas_vld;
    assign o_rej_60 = s_r.r60;
    assign o_rej_50 = s_r.r50;
    assign o_ch_err_led = s_r.led;
    assign o_mod_err_led = s_r.mled;
endmodule

//--- rtl/aip_pkg.sv
// shared constants for the analog input parameter and diagnostic bank
package aip_pkg;
    localparam int NCH = 4;
    // access spaces on the link: record set, can index, ethercat object
    localparam logic [1:0] SP_REC = 2'h0;
    localparam logic [1:0] SP_COE = 2'h1;
    localparam logic [1:0] SP_ECAT = 2'h2;
    localparam logic [15:0] REC_DIAG_HDR = 16'h0000;
    localparam logic [15:0] REC_DIAG = 16'h0001;
    localparam logic [15:0] REC_REJ = 16'h0001;
    localparam logic [15:0] REC_FN0 = 16'h0080;
    localparam logic [15:0] IX_PARAM = 16'h3100;
    localparam logic [15:0] IX_DIAG_HDR = 16'h2F00;
    localparam logic [15:0] IX_DIAG = 16'h2F01;
    localparam logic [15:0] IX_ECAT_DIAG = 16'h5005;
    localparam logic [7:0] SX_REJ = 8'h01;
    localparam logic [7:0] SX_DIAG0 = 8'h02;
    localparam logic [7:0] SX_RSVD_LAST = 8'h11;
    localparam logic [7:0] SX_TSTAMP = 8'h13;
    localparam logic [7:0] DIAG_HDR_LEN = 8'h04;
    localparam logic [7:0] DIAG_LEN = 8'h14;
    // parameter values and reset values
    localparam logic [7:0] FN_S7 = 8'h10;
    localparam logic [7:0] FN_S5 = 8'h20;
    localparam logic [7:0] FN_OFF = 8'hFF;
    localparam logic [7:0] RST_REJ = 8'h00;
    localparam logic [7:0] RST_FN = 8'h10;
    localparam logic [1:0] REJ_OFF = 2'h0;
    localparam logic [1:0] REJ_60 = 2'h1;
    localparam logic [1:0] REJ_50 = 2'h2;
    // fixed descriptor bytes
    localparam logic [7:0] MOD_CLASS = 8'h15;
    localparam logic [7:0] CH_KIND = 8'h71;
    localparam logic [7:0] DIAG_BITS = 8'h08;
    localparam logic [7:0] CH_COUNT = 8'h04;
    // value limits, two's complement
    localparam logic signed [15:0] S7_OVER = 16'sh7EFF;
    localparam logic signed [15:0] S7_UNDER = 16'shED00;
    localparam logic signed [15:0] S5_OVER = 16'sh5000;
    localparam logic signed [15:0] S5_UNDER = 16'shF333;
    // 16384/27648 in 0.16 fixed point
    localparam logic [15:0] S5_MUL = 16'h97B4;
    // diagnostic bit positions
    localparam int SUM_FAIL = 0;
    localparam int SUM_EXT = 2;
    localparam int SUM_CH = 3;
    localparam int SUM_AUX = 4;
    localparam int SUM_PRM = 7;
    localparam int CHE_PRM = 0;
    localparam int CHE_UNDER = 6;
    localparam int CHE_OVER = 7;
    // microsecond ticker
    localparam int US_NS = 1000;
    localparam int CLK_NS = 5;
    localparam int CYC_PER_US = US_NS / CLK_NS;
    // coupler software registers
    localparam logic [3:0] CR_CTRL = 4'h0;
    localparam logic [3:0] CR_INDEX = 4'h1;
    localparam logic [3:0] CR_SUB = 4'h2;
    localparam logic [3:0] CR_WDATA = 4'h3;
    localparam logic [3:0] CR_RDATA = 4'h4;
    localparam logic [3:0] CR_STATUS = 4'h5;
    localparam logic [3:0] CR_IRQ_STAT = 4'h6;
    localparam logic [3:0] CR_IRQ_CLR = 4'h7;
    localparam logic [3:0] CR_IRQ_EN = 4'h8;
    localparam logic [3:0] CR_SLOT = 4'h9;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_NACK = 1;
endpackage

//--- rtl/aip_link_if.sv
// link between the bus coupler and the analog input module
`timescale 1ns/1ps
interface aip_link_if;
    logic req;
    logic wr;
    logic [1:0] space;
    logic [15:0] idx;
    logic [7:0] sub;
    logic [7:0] wdata;
    logic [7:0] slot;
    logic ack;
    logic nack;
    logic [31:0] rdata;
    modport dev (input req, wr, space, idx, sub, wdata, slot,
                 output ack, nack, rdata);
    modport cpl (output req, wr, space, idx, sub, wdata, slot,
                 input ack, nack, rdata);
endinterface

//--- rtl/aip_coupler.sv
// bus coupler end: software registers turned into link accesses
`timescale 1ns/1ps
module aip_coupler (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    aip_link_if.cpl lnk
);
    import aip_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } aip_cpl_state_t;

    typedef struct packed {
        aip_cpl_state_t st;
        logic req;
        logic wr;
        logic [1:0] space;
        logic [15:0] idx;
        logic [7:0] sub;
        logic [7:0] wdata;
        logic [7:0] slot;
        logic [31:0] rd_val;
        logic last_nack;
        logic [1:0] stat;
        logic [1:0] en;
        logic irq;
        logic [31:0] rdata;
    } aip_cpl_st_t;

    aip_cpl_st_t c_r;
    aip_cpl_st_t c_nxt;
    logic [1:0] ev;

    always_comb begin
        c_nxt = c_r;
        c_nxt.req = 1'b0;
        c_nxt.rdata = 32'h0000_0000;
        ev = 2'b00;

        // one request in flight; a start while waiting is ignored
        case (c_r.st)
            ST_IDLE: begin
                if (i_wr && i_addr == CR_CTRL && i_wdata[0]) begin
                    c_nxt.req = 1'b1;
                    c_nxt.wr = i_wdata[1];
                    c_nxt.space = i_wdata[3:2];
                    c_nxt.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (lnk.ack) begin
                    c_nxt.rd_val = lnk.rdata;
                    c_nxt.last_nack = lnk.nack;
                    ev[IRQ_DONE] = 1'b1;
                    ev[IRQ_NACK] = lnk.nack;
                    c_nxt.st = ST_IDLE;
                end
            end
            default: c_nxt.st = ST_IDLE;
        endcase

        // setup registers and interrupt control
        if (i_wr) begin
            case (i_addr)
                CR_INDEX: c_nxt.idx = i_wdata[15:0];
                CR_SUB: c_nxt.sub = i_wdata[7:0];
                CR_WDATA: c_nxt.wdata = i_wdata[7:0];
                CR_IRQ_CLR: c_nxt.stat = c_r.stat & ~i_wdata[1:0];
                CR_IRQ_EN: c_nxt.en = i_wdata[1:0];
                CR_SLOT: c_nxt.slot = i_wdata[7:0];
                default: begin
                end
            endcase
        end
        // a new event beats a clear in the same cycle
        c_nxt.stat = c_nxt.stat | ev;
        c_nxt.irq = |(c_nxt.stat & c_nxt.en);

        // read data is presented in the cycle after the strobe only
        if (i_rd) begin
            case (i_addr)
                CR_INDEX: c_nxt.rdata = {16'h0, c_r.idx};
                CR_SUB: c_nxt.rdata = {24'h0, c_r.sub};
                CR_WDATA: c_nxt.rdata = {24'h0, c_r.wdata};
                CR_RDATA: c_nxt.rdata = c_r.rd_val;
                CR_STATUS: c_nxt.rdata = {30'h0, c_r.last_nack,
                                          c_r.st == ST_WAIT};
                CR_IRQ_STAT: c_nxt.rdata = {30'h0, c_r.stat};
                CR_IRQ_EN: c_nxt.rdata = {30'h0, c_r.en};
                CR_SLOT: c_nxt.rdata = {24'h0, c_r.slot};
                default: c_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            c_r <= '0;
            c_r.st <= ST_IDLE;
        end else if (i_ce) begin
            c_r <= c_nxt;
        end
    end

    assign o_rdata = c_r.rdata;
    assign o_irq = c_r.irq;
    assign lnk.req = c_r.req;
    assign lnk.wr = c_r.wr;
    assign lnk.space = c_r.space;
    assign lnk.idx = c_r.idx;
    assign lnk.sub = c_r.sub;
    assign lnk.wdata = c_r.wdata;
    assign lnk.slot = c_r.slot;
endmodule

//--- verification/aip_link_props.sv
// concurrent checks on the link between coupler and module
`timescale 1ns/1ps
module aip_link_props
    import aip_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic req,
    input wire logic wr,
    input wire logic [1:0] space,
    input wire logic [15:0] idx,
    input wire logic [7:0] sub,
    input wire logic [7:0] wdata,
    input wire logic [7:0] slot,
    input wire logic ack,
    input wire logic nack,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    // answers come only on request, one cycle late
    chk_ack_after_req: assert property (
        req |=> ack) else $error("no ack after request");
    chk_ack_needs_req: assert property (
        ack |-> $past(req)) else $error("ack without request");
    chk_nack_with_ack: assert property (
        nack |-> ack) else $error("nack without ack");
    // read data is zero outside answers so stale bytes never leak
    chk_idle_rdata_zero: assert property (
        !ack |-> rdata == 32'h0) else $error("rdata not zero");
    chk_hdr_len: assert property (
        req && !wr && space == SP_REC && idx == REC_DIAG_HDR
        && sub >= DIAG_HDR_LEN |=> nack) else $error("header overrun");
    chk_hdr_can: assert property (
        req && !wr && space == SP_COE && idx == IX_DIAG_HDR
        && sub < DIAG_HDR_LEN |=> !nack) else $error("header refused");
    chk_ecat_class_byte: assert property (
        req && !wr && space == SP_ECAT && idx == IX_ECAT_DIAG
        && sub == 8'h03 |=> rdata == 32'h15 && !nack)
        else $error("wrong class byte");
    chk_ecat_param_slot: assert property (
        req && space == SP_ECAT && idx == IX_PARAM + 16'(slot)
        && sub >= 8'h01 && sub <= 8'h05 |=> !nack)
        else $error("slot parameter refused");
    chk_full_record_kind: assert property (
        req && !wr && space == SP_REC && idx == REC_DIAG
        && sub == 8'h04 |=> rdata == 32'h71) else $error("bad kind byte");
    // main traffic kinds
    cover property (req && wr);
    cover property (ack && nack);
    cover property (req && space == SP_ECAT);
endmodule

//--- verification/analog_input_param_diag_bank_tb.sv
// self-checking bench: coupler and module joined by the link
`timescale 1ns/1ps
module analog_input_param_diag_bank_tb;
    import aip_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic o_irq;
    logic i_smp_vld = 1'b0;
    logic [1:0] i_smp_ch = 2'h0;
    logic signed [15:0] i_smp_val = 16'sh0;
    logic i_supply_ok = 1'b1;
    logic [NCH-1:0][15:0] o_meas;
    logic [NCH-1:0] o_meas_vld;
    logic [NCH-1:0] o_rej_60;
    logic [NCH-1:0] o_rej_50;
    logic [NCH-1:0] o_ch_err_led;
    logic o_mod_err_led;
    logic [31:0] lrd;
    logic [31:0] st;
    logic [7:0] desc [8] = '{8'h00, 8'h15, 8'h00, 8'h00,
                             8'h71, 8'h08, 8'h04, 8'h00};
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    aip_link_if lnk ();
    always #2.5 i_clk_sys = ~i_clk_sys;
    aip_coupler aip_coupler_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
        .i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .lnk(lnk));
    aip_module aip_module_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
        .i_ce(1'b1), .lnk(lnk), .i_smp_vld(i_smp_vld),
        .i_smp_ch(i_smp_ch), .i_smp_val(i_smp_val),
        .i_supply_ok(i_supply_ok), .o_meas(o_meas),
        .o_meas_vld(o_meas_vld), .o_rej_60(o_rej_60),
        .o_rej_50(o_rej_50), .o_ch_err_led(o_ch_err_led),
        .o_mod_err_led(o_mod_err_led));
    aip_link_props aip_link_props_i (.i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn), .req(lnk.req), .wr(lnk.wr), .space(lnk.space),
        .idx(lnk.idx), .sub(lnk.sub), .wdata(lnk.wdata), .slot(lnk.slot),
        .ack(lnk.ack), .nack(lnk.nack), .rdata(lnk.rdata));
    task automatic end_of_test();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // software port: one-cycle strobes, read data the cycle after
    task automatic swr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic srd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask
    // one link access; the answer lands three cycles after the start
    task automatic acc(input logic [1:0] sp, input logic [15:0] ix,
        input logic [7:0] sx, input logic w, input logic [7:0] wd);
        swr(CR_INDEX, {16'h0, ix});
        swr(CR_SUB, {24'h0, sx});
        swr(CR_WDATA, {24'h0, wd});
        swr(CR_CTRL, {28'h0, sp, w, 1'b1});
        repeat (3) @(posedge i_clk_sys);
        srd(CR_STATUS, st);
        srd(CR_RDATA, lrd);
    endtask
    task automatic rdx(input logic [1:0] sp, input logic [15:0] ix,
        input logic [7:0] sx, input logic [31:0] e, input logic en);
        acc(sp, ix, sx, 1'b0, 8'h00);
        chk(lrd, e);
        chk(32'(st[1]), 32'(en));
    endtask
    task automatic smp(input logic [1:0] c, input logic signed [15:0] v);
        @(posedge i_clk_sys);
        i_smp_vld <= 1'b1;
        i_smp_ch <= c;
        i_smp_val <= v;
        @(posedge i_clk_sys);
        i_smp_vld <= 1'b0;
        // look while the one-cycle valid pulse still stands
        #1;
    endtask
    // hang guard, far above the fewer than one thousand cycles the run needs
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        repeat (12) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            rdx(SP_REC, REC_DIAG, 8'(k), 32'(desc[k]), 1'b0);
        end
        for (int k = 0; k < 5; k++) begin
            rdx(SP_COE, IX_PARAM + 16'(k), 8'h00,
                (k == 0) ? 32'h00 : 32'h10, 1'b0);
        end
        rdx(SP_REC, REC_DIAG_HDR, 8'h01, 32'h15, 1'b0);
        rdx(SP_REC, REC_DIAG_HDR, 8'h04, 32'h00, 1'b1);
        rdx(SP_COE, IX_DIAG_HDR, 8'h03, 32'h00, 1'b0);
        rdx(SP_COE, IX_DIAG, 8'h06, 32'h04, 1'b0);
        rdx(SP_ECAT, IX_ECAT_DIAG, 8'h03, 32'h15, 1'b0);
        rdx(SP_ECAT, IX_ECAT_DIAG, 8'h08, 32'h04, 1'b0);
        rdx(SP_ECAT, IX_ECAT_DIAG, 8'h12, 32'h00, 1'b1);
        // per-channel rejection: ch1 60 Hz, ch2 50 Hz, others off
        acc(SP_REC, REC_REJ, 8'h00, 1'b1, 8'h24);
        chk(32'(o_rej_60), 32'h2);
        chk(32'(o_rej_50), 32'h4);
        swr(CR_SLOT, 32'h3);
        acc(SP_ECAT, IX_PARAM + 16'h3, 8'h01, 1'b1, 8'h08);
        rdx(SP_COE, IX_PARAM, 8'h00, 32'h08, 1'b0);
        rdx(SP_ECAT, IX_PARAM + 16'h3, 8'h02, 32'h10, 1'b0);
        acc(SP_REC, REC_FN0 + 16'h1, 8'h00, 1'b1, 8'h20);
        acc(SP_REC, REC_FN0 + 16'h2, 8'h00, 1'b1, 8'hFF);
        // ch0 nominal, then overflow, recovery and underflow
        smp(2'h0, 16'sh6C00);
        chk(32'(o_meas_vld[0]), 32'h1);
        chk(32'(o_meas[0]), 32'h6C00);
        smp(2'h0, 16'sh7F58);
        chk(32'(o_meas[0]), 32'h7EFF);
        chk(32'(o_ch_err_led[0]), 32'h1);
        chk(32'(o_mod_err_led), 32'h1);
        rdx(SP_REC, REC_DIAG, 8'h00, 32'h0D, 1'b0);
        rdx(SP_REC, REC_DIAG, 8'h07, 32'h01, 1'b0);
        rdx(SP_REC, REC_DIAG, 8'h08, 32'h80, 1'b0);
        acc(SP_ECAT, IX_ECAT_DIAG, 8'h13, 1'b0, 8'h00);
        chk(32'(lrd != 32'h0), 32'h1);
        smp(2'h0, 16'sh0064);
        chk(32'(o_ch_err_led[0]), 32'h0);
        chk(32'(o_mod_err_led), 32'h0);
        smp(2'h0, 16'shECDC);
        chk(32'(o_meas[0]), 32'hED00);
        rdx(SP_REC, REC_DIAG, 8'h08, 32'h40, 1'b0);
        smp(2'h0, 16'sh0000);
        // full scale in the 16384-based format
        smp(2'h1, 16'sh6C00);
        chk(32'(o_meas[1]), 32'h4000);
        smp(2'h2, 16'sh03E8);
        chk(32'(o_meas_vld[2]), 32'h0);
        chk(32'(o_meas[2]), 32'h0);
        acc(SP_REC, REC_FN0 + 16'h3, 8'h00, 1'b1, 8'h33);
        acc(SP_REC, REC_DIAG, 8'h00, 1'b0, 8'h00);
        chk(lrd & 32'h81, 32'h81);
        rdx(SP_REC, REC_DIAG, 8'h0B, 32'h01, 1'b0);
        chk(32'(o_ch_err_led[3]), 32'h1);
        acc(SP_REC, REC_FN0 + 16'h3, 8'h00, 1'b1, 8'h10);
        rdx(SP_REC, REC_DIAG, 8'h00, 32'h00, 1'b0);
        @(posedge i_clk_sys);
        i_supply_ok <= 1'b0;
        acc(SP_REC, REC_DIAG, 8'h00, 1'b0, 8'h00);
        chk(lrd & 32'h10, 32'h10);
        @(posedge i_clk_sys);
        i_supply_ok <= 1'b1;
        rdx(SP_REC, REC_DIAG, 8'h00, 32'h00, 1'b0);
        // coupler interrupt: raise, clear, mask, nack source
        swr(CR_IRQ_CLR, 32'h3);
        swr(CR_IRQ_EN, 32'h1);
        rdx(SP_REC, REC_DIAG, 8'h01, 32'h15, 1'b0);
        chk(32'(o_irq), 32'h1);
        swr(CR_IRQ_CLR, 32'h1);
        #1;
        chk(32'(o_irq), 32'h0);
        swr(CR_IRQ_EN, 32'h2);
        rdx(SP_REC, REC_DIAG, 8'h01, 32'h15, 1'b0);
        chk(32'(o_irq), 32'h0);
        rdx(SP_REC, REC_DIAG_HDR, 8'h05, 32'h00, 1'b1);
        chk(32'(o_irq), 32'h1);
        srd(CR_IRQ_STAT, lrd);
        chk(lrd, 32'h3);
        srd(4'hF, lrd);
        chk(lrd, 32'h0);
        end_of_test();
    end
endmodule
